//--- rtl/ddr_read_pkg.sv
package ddr_read_pkg;
   // Data width of the memory bus and the double-width user word.
   localparam int DATA_WIDTH = 72;
   localparam int USER_WIDTH = 2 * DATA_WIDTH;
   // Storage cell depth and pointer width.
   localparam int CELL_DEPTH = 16;
   localparam int PTR_WIDTH = 4;
   // Request word layout.
   localparam int REQ_WIDTH = 36;
   localparam int CMD_LSB = 32;
   localparam int CMD_WIDTH = 4;
   localparam int ADDR_WIDTH = 32;
   localparam logic [3:0] CMD_READ = 4'h5;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   // Command queue depth and nearly-full threshold.
   localparam int QUEUE_DEPTH = 16;
   localparam int QUEUE_PTR = 4;
   localparam logic [4:0] QUEUE_NEARLY_FULL_LEVEL = 5'h0c;
   // Latency measurement limit in cycles.
   localparam int LAT_WIDTH = 5;
   localparam logic [4:0] LAT_MAX = 5'h1f;
   // Beats returned per read burst.
   localparam logic [2:0] BURST_BEATS = 3'h4;
   localparam logic [3:0] DECODE_CYCLES = 4'h2;
endpackage : ddr_read_pkg

//--- rtl/ddr_read_user_interface.sv
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module ddr_read_user_interface (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   // User request side.
   input wire logic cmd_queue_write_strobe,
   input wire logic [35:0] request_address_word,
   output logic cmd_queue_nearly_full,
   output logic startup_done,
   // User read data side.
   output logic read_data_valid,
   output logic [143:0] read_data,
   // Memory command side.
   output logic mem_cmd_valid,
   output logic mem_cmd_is_read,
   output logic [31:0] mem_cmd_address,
   // Memory read data, sampled per edge.
   input wire logic [71:0] mem_rise_data,
   input wire logic [71:0] mem_fall_data,
   input wire logic mem_data_strobe
);

   // ======================================================================
   // State types
   typedef enum logic [2:0] {
      ST_CAL_ISSUE,
      ST_CAL_WAIT,
      ST_IDLE,
      ST_DECODE,
      ST_ISSUE
   } ctrl_state_t;

   typedef struct packed {
      // Shared command queue.
      logic [15:0][35:0] queue;
      logic [3:0] q_wr;
      logic [3:0] q_rd;
      logic [4:0] q_count;
      logic nearly_full;
      // Sequencer.
      ctrl_state_t state;
      logic [35:0] entry;
      logic [3:0] decode_cnt;
      // Latency measurement.
      logic [4:0] lat_cnt;
      logic [4:0] latency;
      logic done;
      // Capture timing.
      logic [4:0] pend_cnt;
      logic [2:0] beats_left;
      // Read buffers.
      logic [15:0][71:0] rise_buf;
      logic [15:0][71:0] fall_buf;
      logic [3:0] b_wr;
      logic [3:0] b_rd;
      // Memory command outputs.
      logic cmd_valid;
      logic cmd_read;
      logic [31:0] cmd_addr;
      // User read outputs.
      logic out_valid;
      logic [143:0] out_data;
   } state_t;

   state_t s_reg;
   state_t s_next;

   // ======================================================================
   // Command decoding
   function automatic logic is_read(input logic [35:0] word);
      return word[ddr_read_pkg::CMD_LSB +: ddr_read_pkg::CMD_WIDTH] == ddr_read_pkg::CMD_READ;
   endfunction : is_read

   logic push;
   logic pop;
   logic capture;
   logic buf_has_data;
   logic launch;

   // ======================================================================
   // Next-state logic
   always_comb begin
      s_next = s_reg;
      // The user must hold off until startup done and nearly-full clear.
      push = cmd_queue_write_strobe && s_reg.q_count != 5'h10;
      pop = 1'b0;
      launch = 1'b0;
      capture = 1'b0;
      buf_has_data = s_reg.b_wr != s_reg.b_rd;
      // Command and data strobes default low; a command pulse lasts one cycle, a read data burst four.
      s_next.cmd_valid = 1'b0;
      s_next.out_valid = 1'b0;
      // Data is captured on the cycle the measured latency expires.
      if (s_reg.beats_left != 3'h0) begin
         capture = 1'b1;
         s_next.beats_left = s_reg.beats_left - 3'h1;
      end
      // The last step of the countdown opens a four-beat capture window.
      if (s_reg.pend_cnt != 5'h0) begin
         s_next.pend_cnt = s_reg.pend_cnt - 5'h1;
         if (s_reg.pend_cnt == 5'h1) begin
            s_next.beats_left = ddr_read_pkg::BURST_BEATS;
         end
      end
      unique case (s_reg.state)
         // A calibration read is issued before anything else is served.
         ST_CAL_ISSUE: begin
            s_next.cmd_valid = 1'b1;
            s_next.cmd_read = 1'b1;
            s_next.cmd_addr = 32'h0000_0000;
            s_next.lat_cnt = 5'h1;
            s_next.state = ST_CAL_WAIT;
         end
         ST_CAL_WAIT: begin
            // The cap ends the count even if no data strobe ever arrives.
            if (mem_data_strobe || s_reg.lat_cnt == ddr_read_pkg::LAT_MAX) begin
               s_next.latency = s_reg.lat_cnt;
               s_next.done = 1'b1;
               s_next.state = ST_IDLE;
            end else begin
               s_next.lat_cnt = s_reg.lat_cnt + 5'h1;
            end
         end
         ST_IDLE: begin
            // Entries leave the queue strictly in the order they arrived.
            if (s_reg.q_count != 5'h0) begin
               pop = 1'b1;
               s_next.entry = s_reg.queue[s_reg.q_rd];
               s_next.decode_cnt = 4'h1;
               s_next.state = ST_DECODE;
            end
         end
         // ST_DECODE lasts one fixed cycle; with the pop cycle that makes two, the worst case allowed.
         ST_DECODE: begin
            // Only the fixed cycle count is modelled here; no field is read.
            if (s_reg.decode_cnt == ddr_read_pkg::DECODE_CYCLES - 4'h1) begin
               s_next.state = ST_ISSUE;
            end else begin
               s_next.decode_cnt = s_reg.decode_cnt + 4'h1;
            end
         end
         ST_ISSUE: begin
            // A read waits for the previous burst to clear the capture window.
            // Writes leave at once; their data path lies outside this block.
            if (!is_read(s_reg.entry) || (s_reg.pend_cnt == 5'h0 && s_reg.beats_left == 3'h0))
               begin
               s_next.cmd_valid = 1'b1;
               s_next.cmd_read = is_read(s_reg.entry);
               s_next.cmd_addr = s_reg.entry[ddr_read_pkg::ADDR_WIDTH-1:0];
               launch = is_read(s_reg.entry);
               s_next.state = ST_IDLE;
            end
         end
      endcase
      // The capture countdown starts in the cycle the read command leaves.
      if (launch) begin
         s_next.pend_cnt = s_reg.latency;
      end
      // A push into a full queue is lost; nearly-full leaves four spare entries.
      if (push) begin
         s_next.queue[s_reg.q_wr] = request_address_word;
         s_next.q_wr = s_reg.q_wr + 4'h1;
      end
      if (pop) begin
         s_next.q_rd = s_reg.q_rd + 4'h1;
      end
      s_next.q_count = s_reg.q_count + {4'h0, push} - {4'h0, pop};
      // Taken from the next count, so the flag never lags the queue.
      s_next.nearly_full = s_next.q_count >= ddr_read_pkg::QUEUE_NEARLY_FULL_LEVEL;
      // Each bit has one rising and one falling 16-deep cell.
      if (capture) begin
         s_next.rise_buf[s_reg.b_wr] = mem_rise_data;
         s_next.fall_buf[s_reg.b_wr] = mem_fall_data;
         s_next.b_wr = s_reg.b_wr + 4'h1;
      end
      // Buffered data is drained one word a cycle; overflow is impossible
      // because only one burst of four beats is ever outstanding.
      if (buf_has_data) begin
         s_next.out_valid = 1'b1;
         // The falling half sits above the rising half in the user word.
         s_next.out_data = {s_reg.fall_buf[s_reg.b_rd], s_reg.rise_buf[s_reg.b_rd]};
         s_next.b_rd = s_reg.b_rd + 4'h1;
      end
   end

   // ======================================================================
   // State register
   // Reset wins over the clock enable; a low enable freezes every field.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s_reg <= '0;
         s_reg.state <= ST_CAL_ISSUE;
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end

   // ======================================================================
   // Outputs
   // Every output is a field of the registered state.
   assign cmd_queue_nearly_full = s_reg.nearly_full;
   assign startup_done = s_reg.done;
   assign read_data_valid = s_reg.out_valid;
   assign read_data = s_reg.out_data;
   assign mem_cmd_valid = s_reg.cmd_valid;
   assign mem_cmd_is_read = s_reg.cmd_read;
   assign mem_cmd_address = s_reg.cmd_addr;
endmodule : ddr_read_user_interface

//--- verif/ddr_read_checker.sv
`timescale 1ns/1ps
module ddr_read_checker (
   // Watched ports.
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic cmd_queue_write_strobe,
   input wire logic cmd_queue_nearly_full,
   input wire logic startup_done,
   input wire logic read_data_valid,
   input wire logic [143:0] read_data,
   input wire logic mem_cmd_valid,
   input wire logic mem_cmd_is_read,
   input wire logic [31:0] mem_cmd_address,
   input wire logic [71:0] mem_rise_data,
   input wire logic [71:0] mem_fall_data
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   cal_read_a:
      assert property ($fell(reset) |=> mem_cmd_valid && mem_cmd_is_read &&
         mem_cmd_address == 32'h0000_0000) else $error("no cal read");
   start_stays_a:
      assert property (startup_done |=> startup_done) else $error("start dropped");
   write_late_a:
      assert property (mem_cmd_valid && !mem_cmd_is_read |-> startup_done) else $error("early");
   read_spacing_a:
      assert property (mem_cmd_valid && mem_cmd_is_read |=>
         (!(mem_cmd_valid && mem_cmd_is_read)) [*4]) else $error("read overlap");
   burst_four_a:
      assert property ($rose(read_data_valid) |-> read_data_valid [*4] ##1 !read_data_valid)
         else $error("burst length");
   data_pairs_a:
      assert property (read_data_valid |-> read_data ==
         {$past(mem_fall_data, 2), $past(mem_rise_data, 2)}) else $error("halves");
   data_held_a:
      assert property (!read_data_valid |-> $stable(read_data)) else $error("not held");
   full_cause_a:
      assert property ($rose(cmd_queue_nearly_full) |-> $past(cmd_queue_write_strobe) ||
         $past(cmd_queue_write_strobe, 2)) else $error("full no push");
   cover property (read_data_valid);
   cover property (cmd_queue_nearly_full);
   cover property (mem_cmd_valid && !mem_cmd_is_read);
endmodule : ddr_read_checker
bind ddr_read_user_interface ddr_read_checker chk (.*);

//--- verif/mem_model.sv
`timescale 1ns/1ps
module mem_model #(parameter int LAT = 6) (
   // Command in.
   input wire logic sys_clk,
   input wire logic mem_cmd_valid,
   input wire logic mem_cmd_is_read,
   // Data out.
   output logic [71:0] mem_rise_data,
   output logic [71:0] mem_fall_data,
   output logic mem_data_strobe
);
   int cnt = 0;
   logic [7:0] nr = 8'h00;
   logic flip = 1'b0;
   logic [7:0] beat;
   always_ff @(posedge sys_clk) begin
      flip <= !flip;
      if (mem_cmd_valid && mem_cmd_is_read) begin
         cnt <= 1;
         nr <= nr + 8'h01;
      end else if (cnt != 0 && cnt < LAT + 4) cnt <= cnt + 1;
      else cnt <= 0;
   end
   assign beat = 8'(cnt - LAT);
   assign mem_data_strobe = (cnt == LAT);
   // Outside a burst the lines toggle, so a capture off by a cycle cannot match.
   assign mem_rise_data = (beat >= 8'h01 && beat <= 8'h04) ? {56'hA5, nr, beat} : {72{flip}};
   assign mem_fall_data = (beat >= 8'h01 && beat <= 8'h04) ? {56'h5A, nr, beat} : {72{!flip}};
endmodule : mem_model

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic sys_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, cmd_queue_write_strobe = 1'b0;
   logic [35:0] request_address_word = 36'h0_0000_0000;
   logic cmd_queue_nearly_full, startup_done, read_data_valid, mem_cmd_valid, mem_cmd_is_read;
   logic mem_data_strobe, saw_full = 1'b0;
   logic [143:0] read_data;
   logic [31:0] mem_cmd_address;
   logic [71:0] mem_rise_data, mem_fall_data;
   logic [32:0] cmds[$];
   logic [143:0] words[$];
   int n_mismatch = 0, n_checks = 0;
   ddr_read_user_interface DUT (.*);
   mem_model #(.LAT(6)) partner (.*);
   initial forever #12.5 sys_clk = !sys_clk;
   always @(posedge sys_clk) begin
      if (mem_cmd_valid) cmds.push_back({mem_cmd_is_read, mem_cmd_address});
      if (read_data_valid) words.push_back(read_data);
      if (cmd_queue_nearly_full) saw_full = 1'b1;
   end
   task check(input logic [143:0] got, input logic [143:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %h vs %h", $time, got, exp);
      end
   endtask : check
   task wrap_up;
      if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : wrap_up
   task push(input logic [3:0] code, input logic [31:0] addr);
      int t;
      @(posedge sys_clk);
      for (t = 0; t < 500 && cmd_queue_nearly_full !== 1'b0; t++) begin
         cmd_queue_write_strobe <= 1'b0;
         @(posedge sys_clk);
      end
      if (t == 500) begin n_mismatch++; wrap_up(); end
      cmd_queue_write_strobe <= 1'b1;
      request_address_word <= {code, addr};
   endtask : push
   initial begin
      int t;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      for (t = 0; t < 500 && startup_done !== 1'b1; t++) @(posedge sys_clk);
      if (t == 500) begin n_mismatch++; wrap_up(); end
      push(4'h4, 32'h0000_0100);
      push(4'h7, 32'h0000_0200);
      for (int j = 1; j <= 14; j++) push(ddr_read_pkg::CMD_READ, 32'h0000_1000 + 32'(j));
      @(posedge sys_clk);
      cmd_queue_write_strobe <= 1'b0;
      for (t = 0; t < 3000 && (words.size() == 0 || words[$][15:0] !== 16'h0F04); t++)
         @(posedge sys_clk);
      if (t == 3000) n_mismatch++;
      check(144'(saw_full), 144'h1);
      for (int k = 0; k < 16; k++) check(144'(cmds[cmds.size() - 16 + k]), 144'(k < 2 ?
         {1'b0, 24'h0, 8'(k + 1), 8'h00} : {1'b1, 32'h1000 + 32'(k - 1)}));
      for (int k = 0; k < 56; k++) check(words[words.size() - 56 + k], {56'h5A, 8'(k / 4 + 2),
         8'(k % 4 + 1), 56'hA5, 8'(k / 4 + 2), 8'(k % 4 + 1)});
      wrap_up();
   end
endmodule : testbench
